// *** src/bdc_consts.svh ***
// Constants for the buck regulator voltage control block.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef BDC_CONSTS_SVH
`define BDC_CONSTS_SVH
`define BDC_NCONV 6
`define BDC_VW 8
`define BDC_CLK_NS 20
`define BDC_SOFT_START_US 3000
`define BDC_SOFT_START_CYC ((`BDC_SOFT_START_US * 1000) / `BDC_CLK_NS)
`define BDC_STEP_MV 10
`define BDC_SLEW_NS_BASE 500
`define BDC_FLOOR_CODE 8'h46
`define BDC_SLOT_ZERO 4'h0
`define BDC_SEQ_W 4
`define BDC_CORE1 0
`define BDC_CORE2 1
`define BDC_PRO 2
`define BDC_MEM 3
`define BDC_IO 4
`define BDC_SENSE_DIFF 3'h0
`endif

// *** src/bdc_pkg.sv ***
// Types for the buck regulator voltage control block.
// Assumes bdc_consts.svh is included by every user.
package bdc_pkg;
  typedef enum logic [1:0] {
    BDC_MODE_AUTO = 2'h0,
    BDC_MODE_PWM = 2'h1,
    BDC_MODE_PFM = 2'h2
  } bdc_mode_e;
  typedef enum logic [2:0] {
    BDC_ST_IDLE = 3'h1,
    BDC_ST_SOFT = 3'h2,
    BDC_ST_RAMP = 3'h4
  } bdc_state_e;
  typedef struct packed {
    logic [7:0] target;
    logic [7:0] level;
    logic busy;
    logic pfm;
  } bdc_ramp_s;
endpackage

// *** src/bdc_ramp.sv ***
// One converter's soft-start and slew ramp towards a target code.
// Assumes a shared slew tick pulse from the parent.
`include "bdc_consts.svh"
module bdc_ramp (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic softStartOn,
  input wire logic slewTick,
  input wire logic [7:0] target,
  output bdc_pkg::bdc_ramp_s status,
  output logic softLimit
);
  bdc_pkg::bdc_state_e state_q;
  logic [7:0] level_q;
  logic pfm_q;
  logic [31:0] softCnt_q;
  logic [7:0] goal;
  // Ramps down stop at the floor; below it only PFM is allowed
  assign goal = (target < `BDC_FLOOR_CODE && level_q >= `BDC_FLOOR_CODE) ?
                `BDC_FLOOR_CODE : target;
  always_ff @(posedge core_clk) begin
    if (srst || !enable) begin
      state_q <= bdc_pkg::BDC_ST_IDLE;
      softCnt_q <= 32'h0;
    end else begin
      case (state_q)
        bdc_pkg::BDC_ST_IDLE: begin
          state_q <= softStartOn ? bdc_pkg::BDC_ST_SOFT : bdc_pkg::BDC_ST_RAMP;
          softCnt_q <= 32'h0;
        end
        bdc_pkg::BDC_ST_SOFT: begin
          softCnt_q <= softCnt_q + 32'h1;
          if (softCnt_q >= `BDC_SOFT_START_CYC - 1) begin
            state_q <= bdc_pkg::BDC_ST_RAMP;
          end
        end
        bdc_pkg::BDC_ST_RAMP: state_q <= bdc_pkg::BDC_ST_RAMP;
        default: state_q <= bdc_pkg::BDC_ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      level_q <= 8'h0;
    end else if (!enable) begin
      level_q <= target;
    end else if (state_q != bdc_pkg::BDC_ST_RAMP) begin
      level_q <= target;
    end else if (slewTick && level_q < goal) begin
      level_q <= level_q + 8'h1;
    end else if (slewTick && level_q > goal) begin
      level_q <= level_q - 8'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pfm_q <= 1'b0;
    end else begin
      pfm_q <= target < `BDC_FLOOR_CODE;
    end
  end
  assign softLimit = state_q == bdc_pkg::BDC_ST_SOFT;
  assign status.target = target;
  assign status.level = level_q;
  assign status.busy = enable && state_q == bdc_pkg::BDC_ST_RAMP && level_q != goal;
  assign status.pfm = pfm_q;
endmodule

// *** src/bdc_control.sv ***
// Control for six step-down converters: enables, voltage select, slew, modes,
// sequencer and input-driven updates, merge and termination options.
// Assumes all inputs synchronous to core_clk; sequencer pulses last one cycle.
// Function
// - Soft-start limits current for 3 ms after enable when selected.
// - Voltage targets programmable in 10 mV code steps.
// - Ready pin asserted while slewing; ramp done event when all finish.
// - Reductions below 0.7 V stop at 0.7 V and force PFM.
// - Selected register write ramps now; unselected waits for select toggle.
// - Shared slew rate 10 mV per 4, 2, 1 or 0.5 us.
// - Per-converter mode: forced PWM, forced PFM or automatic.
// - Enable and select writes apply unless a join option locks the rail; reads show actual state.
// - Sequencer IDs; default reload when power-up sequencer passes slot 0.
// - Power-up slot match clears select bit, ramp to setting A.
// - Power-down disables, or stay-on converters set select for B.
// - Input 1, 2 or 13 may drive enable and voltage select.
// - Input edge updates enabled regulators and clears its event bit.
// - Register write colliding with input update is delayed and wins.
// - Sequencer leaves input-controlled settings untouched.
// - Reset power state disables every converter.
// - Full-current option doubles current limit, raises capability to 2500 mA.
// - Dual-phase join ignores core two enable, select and setting writes; discharge off still works.
// - Sense select 0b000 enables remote sensing in dual-phase join; pin choice control.
// - Core two switches on inverted clock of core one.
// - Termination tracking, reference output, else event and comparator state.
// - Memory/io join disables io enable, select and setting writes and doubles memory limit.
`include "bdc_consts.svh"
module bdc_control (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [5:0] wrEnable,
  input wire logic [5:0] wrEnableVal,
  input wire logic [5:0] wrSelect,
  input wire logic [5:0] wrSelectVal,
  input wire logic [5:0] wrSettingA,
  input wire logic [5:0] wrSettingB,
  input wire logic [7:0] wrVoltage,
  input wire logic [1:0] slewRate,
  input wire logic softStartEn,
  input wire logic [11:0] modeSel,
  input wire logic [5:0] stayOnAtPowerdown,
  input wire logic [23:0] seqId,
  input wire logic defaultReloadOption,
  input wire logic [47:0] defaultVoltage,
  input wire logic seqPowerUp,
  input wire logic seqPowerDown,
  input wire logic [3:0] seqSlot,
  input wire logic enterResetState,
  input wire logic [5:0] inputDrivenOnOff,
  input wire logic [5:0] inputDrivenVoltageSelect,
  input wire logic [11:0] inputSource,
  input wire logic inputOne,
  input wire logic inputTwo,
  input wire logic inputThirteen,
  input wire logic feedbackPinOneReady,
  input wire logic rampDoneClear,
  input wire logic rampDoneMask,
  input wire logic [2:0] fullCurrent,
  input wire logic dualPhaseJoin,
  input wire logic [2:0] coreOneSenseSelect,
  input wire logic remoteSensePinChoice,
  input wire logic terminationTrackingEnable,
  input wire logic terminationReferenceEnable,
  input wire logic comparatorState,
  input wire logic memoryIoJoin,
  input wire logic [5:0] dischargeResistorOff,
  input wire logic phaseClock,
  output logic [5:0] enableState,
  output logic [5:0] selectState,
  output logic [47:0] voltageLevel,
  output logic [11:0] modeOut,
  output logic [5:0] softLimit,
  output logic [5:0] limitDouble,
  output logic [5:0] dischargeOn,
  output logic feedbackPinOne,
  output logic voltageRampDoneEvent,
  output logic rampIrq,
  output logic [2:0] inputEventClear,
  output logic remoteSenseOn,
  output logic senseOnCorePin,
  output logic coreTwoClock,
  output logic halfSenseTrack,
  output logic referenceDrive,
  output logic terminationSensePin,
  output logic terminationReferencePin
);
  logic [5:0] en_q;
  logic [5:0] sel_q;
  logic [7:0] setA_q [`BDC_NCONV];
  logic [7:0] setB_q [`BDC_NCONV];
  logic [2:0] inPrev_q;
  logic [2:0] inNow;
  logic [2:0] inEdge;
  logic [5:0] hold_q;
  logic [5:0] holdEnVal_q;
  logic [5:0] holdSelVal_q;
  logic [5:0] holdSelWr_q;
  logic [9:0] slewCnt_q;
  logic [9:0] slewLimit;
  logic slewTick;
  logic [5:0] busy;
  logic [5:0] writable;
  logic [5:0] hwUpd;
  logic [5:0] hwLevel;
  logic anyBusy_q;
  logic rampDone_q;
  logic [5:0] slotMatch;

  // Rail may be touched by software; join options lock some out
  function automatic logic railWritable(input int i, input logic dp, input logic mj);
    railWritable = !((i == `BDC_CORE2 && dp) || (i == `BDC_IO && mj));
  endfunction

  function automatic logic pickInput(input logic [1:0] src, input logic [2:0] v);
    case (src)
      2'h0: pickInput = v[0];
      2'h1: pickInput = v[1];
      2'h2: pickInput = v[2];
      default: pickInput = 1'b0;
    endcase
  endfunction

  assign inNow = {inputThirteen, inputTwo, inputOne};
  assign inEdge = inNow ^ inPrev_q;
  assign inputEventClear = inEdge;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      inPrev_q <= 3'h0;
    end else begin
      inPrev_q <= inNow;
    end
  end

  // Shared slew divider: 25 cycles per 0.5 us doubled per setting
  assign slewLimit = 10'((`BDC_SLEW_NS_BASE / `BDC_CLK_NS) << slewRate) - 10'h1;
  assign slewTick = slewCnt_q == slewLimit;
  always_ff @(posedge core_clk) begin
    if (srst || slewTick) begin
      slewCnt_q <= 10'h0;
    end else begin
      slewCnt_q <= slewCnt_q + 10'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `BDC_NCONV; g++) begin : gConv
      bdc_pkg::bdc_ramp_s st;
      logic [7:0] tgt;
      logic [1:0] src;
      assign src = inputSource[2*g +: 2];
      assign writable[g] = railWritable(g, dualPhaseJoin, memoryIoJoin);
      assign hwLevel[g] = pickInput(src, inNow);
      assign hwUpd[g] = pickInput(src, inEdge) &&
                        (inputDrivenOnOff[g] || inputDrivenVoltageSelect[g]);
      assign slotMatch[g] = seqId[4*g +: 4] == seqSlot;
      // Select picks live target, so a select write ramps at once
      assign tgt = sel_q[g] ? setB_q[g] : setA_q[g];
      bdc_ramp uRamp (
        .core_clk(core_clk),
        .srst(srst),
        .enable(en_q[g]),
        .softStartOn(softStartEn),
        .slewTick(slewTick),
        .target(tgt),
        .status(st),
        .softLimit(softLimit[g])
      );
      assign busy[g] = st.busy;
      assign voltageLevel[8*g +: 8] = st.level;
      // Forced modes pass; floor crossing overrides to PFM
      assign modeOut[2*g +: 2] = st.pfm ? 2'(bdc_pkg::BDC_MODE_PFM) :
                                 modeSel[2*g +: 2];

      always_ff @(posedge core_clk) begin
        if (srst) begin
          setA_q[g] <= 8'h0;
          setB_q[g] <= 8'h0;
        end else if (seqPowerUp && seqSlot == `BDC_SLOT_ZERO && defaultReloadOption &&
                     !inputDrivenVoltageSelect[g]) begin
          setA_q[g] <= defaultVoltage[8*g +: 8];
        end else if (writable[g]) begin
          if (wrSettingA[g]) setA_q[g] <= wrVoltage;
          if (wrSettingB[g]) setB_q[g] <= wrVoltage;
        end
      end

      // Write colliding with input update is parked one cycle
      always_ff @(posedge core_clk) begin
        if (srst) begin
          hold_q[g] <= 1'b0;
          holdEnVal_q[g] <= 1'b0;
          holdSelVal_q[g] <= 1'b0;
          holdSelWr_q[g] <= 1'b0;
        end else begin
          hold_q[g] <= hwUpd[g] && writable[g] && (wrEnable[g] || wrSelect[g]);
          // Select-only write must not undo the input-driven enable
          holdEnVal_q[g] <= wrEnable[g] ? wrEnableVal[g] :
                            (inputDrivenOnOff[g] ? hwLevel[g] : en_q[g]);
          holdSelVal_q[g] <= wrSelectVal[g];
          holdSelWr_q[g] <= wrSelect[g];
        end
      end

      always_ff @(posedge core_clk) begin
        if (srst || enterResetState) begin
          en_q[g] <= 1'b0;
        end else if (hold_q[g]) begin
          en_q[g] <= holdEnVal_q[g];
        end else if (hwUpd[g] && inputDrivenOnOff[g]) begin
          en_q[g] <= hwLevel[g];
        end else if (wrEnable[g] && writable[g]) begin
          en_q[g] <= wrEnableVal[g];
        end else if (seqPowerDown && slotMatch[g] && !inputDrivenOnOff[g] &&
                     !stayOnAtPowerdown[g]) begin
          en_q[g] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk) begin
        if (srst) begin
          sel_q[g] <= 1'b0;
        end else if (hold_q[g] && holdSelWr_q[g]) begin
          sel_q[g] <= holdSelVal_q[g];
        end else if (hwUpd[g] && inputDrivenVoltageSelect[g]) begin
          sel_q[g] <= hwLevel[g];
        end else if (wrSelect[g] && writable[g]) begin
          sel_q[g] <= wrSelectVal[g];
        end else if (seqPowerUp && slotMatch[g] && !inputDrivenVoltageSelect[g]) begin
          sel_q[g] <= 1'b0;
        end else if (seqPowerDown && slotMatch[g] && stayOnAtPowerdown[g] &&
                     !inputDrivenVoltageSelect[g]) begin
          sel_q[g] <= 1'b1;
        end
      end

      assign dischargeOn[g] = !en_q[g] && !dischargeResistorOff[g];
    end
  endgenerate

  assign enableState = en_q;
  assign selectState = sel_q;

  // Current limit doubling for full-current and merged memory rail
  assign limitDouble = {1'b0, 1'b0, memoryIoJoin,
                        fullCurrent[2], fullCurrent[1], fullCurrent[0]};

  assign feedbackPinOne = feedbackPinOneReady && (|busy);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      anyBusy_q <= 1'b0;
    end else begin
      anyBusy_q <= |busy;
    end
  end
  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rampDone_q <= 1'b0;
    end else if (feedbackPinOneReady && anyBusy_q && !(|busy)) begin
      rampDone_q <= 1'b1;
    end else if (rampDoneClear) begin
      rampDone_q <= 1'b0;
    end
  end
  assign voltageRampDoneEvent = rampDone_q;
  assign rampIrq = rampDone_q && !rampDoneMask;

  assign remoteSenseOn = dualPhaseJoin && coreOneSenseSelect == `BDC_SENSE_DIFF;
  assign senseOnCorePin = !remoteSensePinChoice;
  assign coreTwoClock = ~phaseClock;
  assign halfSenseTrack = terminationTrackingEnable;
  assign referenceDrive = terminationReferenceEnable;
  // Pins double as status outputs when no reference is needed
  assign terminationSensePin = !terminationReferenceEnable && inputTwo;
  assign terminationReferencePin = !terminationReferenceEnable && comparatorState;
endmodule

// *** dv/bdc_control_checker.sv ***
// Port checker for the buck converter control block.
// Assumes one clock domain; bound onto bdc_control below.
module bdc_control_checker (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [5:0] wrEnable,
  input wire logic [5:0] wrEnableVal,
  input wire logic [5:0] wrSelect,
  input wire logic [23:0] seqId,
  input wire logic seqPowerUp,
  input wire logic seqPowerDown,
  input wire logic [3:0] seqSlot,
  input wire logic [5:0] stayOnAtPowerdown,
  input wire logic enterResetState,
  input wire logic [5:0] inputDrivenOnOff,
  input wire logic [5:0] inputDrivenVoltageSelect,
  input wire logic [11:0] modeSel,
  input wire logic [2:0] fullCurrent,
  input wire logic memoryIoJoin,
  input wire logic phaseClock,
  input wire logic terminationTrackingEnable,
  input wire logic terminationReferenceEnable,
  input wire logic comparatorState,
  input wire logic rampDoneClear,
  input wire logic rampDoneMask,
  input wire logic [5:0] enableState,
  input wire logic [5:0] selectState,
  input wire logic [11:0] modeOut,
  input wire logic [5:0] limitDouble,
  input wire logic voltageRampDoneEvent,
  input wire logic rampIrq,
  input wire logic coreTwoClock,
  input wire logic halfSenseTrack,
  input wire logic terminationReferencePin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Input-driven updates delay writes, so timing checks skip them
  wire calm = ((inputDrivenOnOff | inputDrivenVoltageSelect) == 6'h00) && !enterResetState;
  wire slotHit = seqSlot == seqId[3:0];
  wire slotHitOne = seqSlot == seqId[7:4];
  a_enable_write: assert property (calm && wrEnable[0] |=> enableState[0] == $past(wrEnableVal[0]))
    else $error("enable write not applied");
  a_reset_off: assert property (enterResetState |=> enableState == 6'h00)
    else $error("converter left on in reset state");
  a_powerup_sel: assert property (calm && seqPowerUp && slotHit && !wrSelect[0] |=> !selectState[0])
    else $error("power-up slot did not clear select");
  a_powerdown_off: assert property (calm && seqPowerDown && slotHit && !stayOnAtPowerdown[0]
    && !wrEnable[0] |=> !enableState[0]) else $error("power-down slot left converter on");
  a_stay_on: assert property (calm && seqPowerDown && slotHitOne && stayOnAtPowerdown[1]
    && !wrSelect[1] && !wrEnable[1]
    |=> selectState[1] && enableState[1] == $past(enableState[1]))
    else $error("stay-on converter not moved to setting B");
  a_pfm_forced: assert property (modeSel[11:10] == 2'h2 |-> modeOut[11:10] == 2'h2)
    else $error("forced PFM not honoured");
  a_full_current: assert property (limitDouble[0] == fullCurrent[0] && limitDouble[2] == fullCurrent[2])
    else $error("full-current doubling wrong");
  a_mem_double: assert property (limitDouble[3] == memoryIoJoin)
    else $error("memory limit doubling wrong");
  a_anti_phase: assert property (coreTwoClock == !phaseClock)
    else $error("core two clock not inverted");
  a_term_pins: assert property (halfSenseTrack == terminationTrackingEnable && (terminationReferenceEnable
    || terminationReferencePin == comparatorState)) else $error("termination pins wrong");
  a_done_sticky: assert property (voltageRampDoneEvent && !rampDoneClear |=> voltageRampDoneEvent)
    else $error("ramp done event dropped");
  a_irq_mask: assert property (rampIrq == (voltageRampDoneEvent && !rampDoneMask))
    else $error("ramp interrupt masking wrong");
  c_powerup: cover property (seqPowerUp && slotHit);
  c_masked: cover property (voltageRampDoneEvent && !rampIrq);
  c_reset_state: cover property (enterResetState);
endmodule

bind bdc_control bdc_control_checker checker_i (.core_clk, .srst, .wrEnable, .wrEnableVal, .wrSelect,
  .seqId, .seqPowerUp, .seqPowerDown, .seqSlot, .stayOnAtPowerdown, .enterResetState,
  .inputDrivenOnOff, .inputDrivenVoltageSelect, .modeSel, .fullCurrent, .memoryIoJoin, .phaseClock,
  .terminationTrackingEnable, .terminationReferenceEnable, .comparatorState, .rampDoneClear,
  .rampDoneMask, .enableState, .selectState, .modeOut, .limitDouble, .voltageRampDoneEvent, .rampIrq,
  .coreTwoClock, .halfSenseTrack, .terminationReferencePin);

// *** dv/bdc_host_model.sv ***
// Host model issuing one-cycle register writes to the converter controls.
// Assumes the block samples strobes on the rising edge of core_clk.
module bdc_host_model (
  input wire logic core_clk,
  output logic [5:0] wrEnable,
  output logic [5:0] wrEnableVal,
  output logic [5:0] wrSelect,
  output logic [5:0] wrSelectVal,
  output logic [5:0] wrSettingA,
  output logic [5:0] wrSettingB,
  output logic [7:0] wrVoltage
);
  initial begin
    {wrEnable, wrEnableVal, wrSelect, wrSelectVal, wrSettingA, wrSettingB} = 36'h0;
    wrVoltage = 8'h00;
  end
  // Kind 0 enable, 1 select, 2 setting A, 3 setting B
  task automatic post(input logic [1:0] kind, input int idx, input logic [7:0] val);
    @(negedge core_clk);
    wrVoltage = val;
    wrEnableVal[idx] = val[0];
    wrSelectVal[idx] = val[0];
    case (kind)
      2'h0: wrEnable[idx] = 1'b1;
      2'h1: wrSelect[idx] = 1'b1;
      2'h2: wrSettingA[idx] = 1'b1;
      default: wrSettingB[idx] = 1'b1;
    endcase
    @(negedge core_clk);
    {wrEnable, wrSelect, wrSettingA, wrSettingB} = 24'h0;
  endtask
endmodule

// *** dv/test_buck_regulator_dvc_control.sv ***
// Self-checking bench for the buck converter control block.
// Assumes the host model issues writes; all other inputs driven here.
module test_buck_regulator_dvc_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, srst = 1'b1, phaseClock = 1'b0, inputOne = 1'b0;
  logic seqPowerUp = 1'b0, seqPowerDown = 1'b0, enterResetState = 1'b0, rampDoneClear = 1'b0;
  logic rampDoneMask = 1'b0, memoryIoJoin = 1'b0, comparatorState = 1'b0;
  logic terminationTrackingEnable = 1'b0, terminationReferenceEnable = 1'b0;
  logic inputTwo = 1'b0, softStartEn = 1'b0, defaultReloadOption = 1'b0, dualPhaseJoin = 1'b0;
  logic [1:0] slewRate = 2'h0;
  logic [2:0] fullCurrent = 3'h0, coreOneSenseSelect = 3'h1;
  logic [3:0] seqSlot = 4'h0;
  logic [5:0] stayOnAtPowerdown = 6'h02, inputDrivenOnOff = 6'h00;
  logic [5:0] inputDrivenVoltageSelect = 6'h00;
  logic [11:0] modeSel = 12'h000, inputSource = 12'h000;
  logic [23:0] seqId = 24'h000021;
  logic [47:0] defaultVoltage = 48'h0;
  logic [5:0] wrEnable, wrEnableVal, wrSelect, wrSelectVal, wrSettingA, wrSettingB;
  logic [5:0] enableState, selectState, limitDouble, softLimit, dischargeOn;
  logic [2:0] inputEventClear;
  logic feedbackPinOne, remoteSenseOn, terminationSensePin;
  logic [7:0] wrVoltage;
  logic [11:0] modeOut;
  logic [47:0] voltageLevel;
  logic voltageRampDoneEvent, rampIrq, coreTwoClock, halfSenseTrack, terminationReferencePin;
  int fails = 0;
  int comparisons = 0;
  int n;
  always #10 core_clk = ~core_clk;
  // Switching clock moves on falling edges, away from the sampling edge
  always @(negedge core_clk) phaseClock <= ~phaseClock;
  bdc_host_model host (.core_clk, .wrEnable, .wrEnableVal, .wrSelect, .wrSelectVal, .wrSettingA,
    .wrSettingB, .wrVoltage);
  bdc_control dut (.core_clk, .srst, .wrEnable, .wrEnableVal, .wrSelect, .wrSelectVal, .wrSettingA,
    .wrSettingB, .wrVoltage, .slewRate, .softStartEn, .modeSel, .stayOnAtPowerdown, .seqId,
    .defaultReloadOption, .defaultVoltage, .seqPowerUp, .seqPowerDown, .seqSlot,
    .enterResetState, .inputDrivenOnOff, .inputDrivenVoltageSelect, .inputSource,
    .inputOne, .inputTwo, .inputThirteen(1'b0), .feedbackPinOneReady(1'b1), .rampDoneClear,
    .rampDoneMask, .fullCurrent, .dualPhaseJoin, .coreOneSenseSelect,
    .remoteSensePinChoice(1'b0), .terminationTrackingEnable, .terminationReferenceEnable,
    .comparatorState, .memoryIoJoin, .dischargeResistorOff(6'h00), .phaseClock, .enableState,
    .selectState, .voltageLevel, .modeOut, .softLimit, .limitDouble, .dischargeOn,
    .feedbackPinOne, .voltageRampDoneEvent, .rampIrq, .inputEventClear, .remoteSenseOn,
    .senseOnCorePin(), .coreTwoClock, .halfSenseTrack, .referenceDrive(),
    .terminationSensePin, .terminationReferencePin);
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic expire(input int lim);
    if (n >= lim) begin
      fails++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      results();
    end
  endtask
  task automatic seq(input logic up, input logic [3:0] slot);
    @(negedge core_clk);
    {seqPowerUp, seqPowerDown, seqSlot} = {up, !up, slot};
    @(negedge core_clk);
    {seqPowerUp, seqPowerDown} = 2'h0;
  endtask
  task automatic tWrite();
    host.post(2'h0, 2, 8'h01);
    check(enableState === 6'h04, "enable write");
    host.post(2'h1, 2, 8'h01);
    check(selectState === 6'h04, "select write");
  endtask
  task automatic tRamp();
    host.post(2'h0, 0, 8'h01);
    host.post(2'h2, 0, 8'h50);
    for (n = 0; n < 2500 && voltageLevel[7:0] !== 8'h50; n++) @(negedge core_clk);
    expire(2500);
    check(n > 1970 && n < 2030, "ramp up time");
    repeat (3) @(negedge core_clk);
    check(voltageRampDoneEvent === 1'b1 && rampIrq === 1'b1, "ramp done event");
    rampDoneMask = 1'b1;
    #1 check(rampIrq === 1'b0, "masked interrupt");
    host.post(2'h3, 0, 8'h4b);
    repeat (100) @(negedge core_clk);
    check(voltageLevel[7:0] === 8'h50, "unselected write held");
    rampDoneClear = 1'b1;
    slewRate = 2'h1;
    @(negedge core_clk);
    rampDoneClear = 1'b0;
    check(voltageRampDoneEvent === 1'b0, "event cleared");
    host.post(2'h1, 0, 8'h01);
    for (n = 0; n < 400 && voltageLevel[7:0] !== 8'h4b; n++) @(negedge core_clk);
    expire(400);
    check(n > 195 && n < 260, "ramp down time");
  endtask
  task automatic tSeq();
    seq(1'b1, 4'h1);
    check(selectState[0] === 1'b0, "power-up select");
    host.post(2'h0, 1, 8'h01);
    seq(1'b0, 4'h2);
    check(enableState[1] === 1'b1 && selectState[1] === 1'b1, "stay on");
    seq(1'b0, 4'h1);
    check(enableState[0] === 1'b0, "power-down off");
  endtask
  task automatic tGpi();
    inputDrivenOnOff = 6'h08;
    repeat (2) @(negedge core_clk);
    inputOne = 1'b1;
    for (n = 0; n < 5 && enableState[3] !== 1'b1; n++) @(negedge core_clk);
    check(n < 5, "input rise enables");
    inputOne = 1'b0;
    for (n = 0; n < 5 && enableState[3] !== 1'b0; n++) @(negedge core_clk);
    check(n < 5, "input fall disables");
    inputDrivenOnOff = 6'h00;
    {inputSource, inputDrivenVoltageSelect} = {12'h040, 6'h08};
    inputTwo = 1'b1;
    #1 check(inputEventClear === 3'h2 && terminationSensePin === 1'b1, "input two edge");
    @(negedge core_clk);
    check(selectState[3] === 1'b1, "input selects setting B");
  endtask
  task automatic tReload();
    {defaultReloadOption, defaultVoltage} = {1'b1, 48'h640000000000};
    seq(1'b1, 4'h0);
    check(selectState[3] === 1'b1, "input-held select kept");
    @(negedge core_clk);
    check(voltageLevel[47:40] === 8'h64, "default reload");
    {defaultReloadOption, inputDrivenVoltageSelect} = {1'b0, 6'h00};
  endtask
  task automatic tFloor();
    host.post(2'h2, 4, 8'h48);
    host.post(2'h0, 4, 8'h01);
    host.post(2'h2, 4, 8'h40);
    check(feedbackPinOne === 1'b1, "ready pin while slewing");
    repeat (300) @(negedge core_clk);
    check(voltageLevel[39:32] === 8'h46, "ramp stops at floor");
    check(modeOut[9:8] === 2'h2 && feedbackPinOne === 1'b0, "floor forces PFM");
  endtask
  task automatic tStatic();
    for (int m = 1; m < 3; m++) begin
      modeSel = {m[1:0], 10'h000};
      #1 check(modeOut[11:10] === m[1:0], "forced mode");
    end
    {fullCurrent, memoryIoJoin} = {3'h5, 1'b1};
    {terminationTrackingEnable, comparatorState} = 2'h3;
    #1 check(limitDouble[3:0] === 4'hd, "limit doubling");
    check(halfSenseTrack === 1'b1 && terminationReferencePin === 1'b1, "termination");
    check(coreTwoClock === ~phaseClock, "anti-phase");
    {dualPhaseJoin, coreOneSenseSelect} = {1'b1, 3'h0};
    host.post(2'h0, 1, 8'h00);
    check(enableState[1] === 1'b1 && remoteSenseOn === 1'b1, "core two refused");
    softStartEn = 1'b1;
    host.post(2'h0, 5, 8'h01);
    @(negedge core_clk);
    check(softLimit[5] === 1'b1, "soft-start limit");
    @(negedge core_clk);
    enterResetState = 1'b1;
    @(negedge core_clk);
    enterResetState = 1'b0;
    check(enableState === 6'h00 && dischargeOn === 6'h3f, "reset state");
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    check(enableState === 6'h00 && voltageLevel === 48'h0, "reset values");
    tWrite();
    tRamp();
    tSeq();
    tGpi();
    tReload();
    tFloor();
    tStatic();
    results();
  end
endmodule
